// [src/iict_top.sv]
// Summary of operation
// - masked bit 24 shows arbitration lost when its enable is set.
// - masked bit 25 shows bus fault when its enable is set.
// - masked bit 28 shows master done without stop when enabled.
// - clear register: writing one clears pending bit; zero ignored; reads zero.
// - clear bit 3 clears transmit overrun pending.
// - clear bits 16-18 clear slave read request, read empty, write request.
// - clear bits 19, 20 clear master done and slave done.
// - clear bits 24, 25, 28 clear arbitration, bus fault, no-stop.
// - clock falling edge seen while idle with no start or restart request starts data-hold count; data driven on reaching it.
// - standard mode start: start-hold count, then clock pulled low.
// - fast mode start: start-hold loaded from quick field instead.
// - standard mode end without stop: setup count, then repeated start.
// - unexpected start or stop mid-transaction sets bus fault and cause code.
// - master done without stop raised; software clears before next operation.
`default_nettype none
module iict_top
   import iict_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Two-wire bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             scl_out,
   output logic             scl_oe,
   output logic             sda_out,
   output logic             sda_oe,
   // Sequencer side
   input  wire logic        seq_in_transaction,
   input  wire logic        seq_start_req,
   input  wire logic        seq_restart_req,
   input  wire logic        seq_tx_bit,
   input  wire logic [31:0] seq_event_set,
   output logic             seq_start_done,
   output logic             seq_restart_done,
   output logic             seq_data_launch,
   // Interrupt
   output logic             irq
);
   logic [8:0]  data_hold_r;
   logic [8:0]  hold_slow_r;
   logic [8:0]  hold_quick_r;
   logic [8:0]  setup_slow_r;
   logic [8:0]  setup_quick_r;
   logic [31:0] raw_r;
   logic [31:0] mask_r;
   logic        fast_mode_r;
   logic [1:0]  cause_r;
   logic [31:0] masked;
   logic        wr_en;
   logic [31:0] clear_bits;
   logic [31:0] ev_set;

   // APB: zero wait states, error on unmapped address
   assign wr_en   = psel && penable && pwrite;
   assign pready  = 1'b1;
   always_comb begin
      case (paddr)
         OFS_MASKED_VIEW, OFS_IRQ_CLEAR, OFS_DATA_HOLD, OFS_START_HOLD, OFS_START_SETUP,
         OFS_RAW_STATUS, OFS_IRQ_MASK, OFS_CONTROL, OFS_FAULT_CAUSE: pslverr = 1'b0;
         default: pslverr = psel && penable;
      endcase
   end

   // Pin synchronisers
   logic [1:0] scl_sync_r;
   logic [1:0] sda_sync_r;
   logic       scl_prev_r;
   logic       sda_prev_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_r <= 2'h3;
         sda_sync_r <= 2'h3;
         scl_prev_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
         scl_prev_r <= scl_sync_r[1];
         sda_prev_r <= sda_sync_r[1];
      end
   end
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   assign scl_fall   = scl_prev_r && !scl_sync_r[1];
   assign start_seen = scl_sync_r[1] && scl_prev_r && sda_prev_r && !sda_sync_r[1];
   assign stop_seen  = scl_sync_r[1] && scl_prev_r && !sda_prev_r && sda_sync_r[1];

   // Bus fault detection
   logic bus_fault_evt;
   logic own_cond_r;
   assign bus_fault_evt = seq_in_transaction && !own_cond_r && (start_seen || stop_seen);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= CAUSE_NONE;
      end else if (bus_fault_evt) begin
         cause_r <= start_seen ? CAUSE_START : CAUSE_STOP;
      end else if (wr_en && paddr == OFS_IRQ_CLEAR && pwdata[BIT_BUS_FAULT]) begin
         cause_r <= CAUSE_NONE;
      end
   end

   // Timing, mask and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_hold_r   <= RST_DATA_HOLD;
         hold_slow_r   <= RST_HOLD_SLOW;
         hold_quick_r  <= RST_HOLD_QUICK;
         setup_slow_r  <= RST_SETUP_SLOW;
         setup_quick_r <= RST_SETUP_QUICK;
         mask_r        <= RST_MASK;
         fast_mode_r   <= 1'b0;
      end else if (wr_en) begin
         case (paddr)
            OFS_DATA_HOLD: data_hold_r <= pwdata[SLOW_LSB +: CNT_W];
            OFS_START_HOLD: begin
               hold_slow_r  <= pwdata[SLOW_LSB +: CNT_W];
               hold_quick_r <= pwdata[QUICK_LSB +: CNT_W];
            end
            OFS_START_SETUP: begin
               setup_slow_r  <= pwdata[SLOW_LSB +: CNT_W];
               setup_quick_r <= pwdata[QUICK_LSB +: CNT_W];
            end
            OFS_IRQ_MASK: mask_r <= pwdata & IRQ_DEFINED_MASK;
            OFS_CONTROL: fast_mode_r <= pwdata[0];
            default: ;
         endcase
      end
   end

   // Raw status: set wins over clear
   assign clear_bits = (wr_en && paddr == OFS_IRQ_CLEAR) ? (pwdata & IRQ_DEFINED_MASK) : 32'h00000000;
   always_comb begin
      ev_set = seq_event_set & IRQ_DEFINED_MASK;
      ev_set[BIT_BUS_FAULT] = seq_event_set[BIT_BUS_FAULT] | bus_fault_evt;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_r <= 32'h00000000;
      end else begin
         // Clear bits 3,16-20,24,25,28
         raw_r <= (raw_r & ~clear_bits) | ev_set;
      end
   end
   assign masked = raw_r & mask_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((((raw_r & ~clear_bits) | ev_set)) & mask_r);
      end
   end

   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            OFS_MASKED_VIEW: prdata <= masked;
            OFS_IRQ_CLEAR:   prdata <= 32'h00000000;
            OFS_DATA_HOLD:   prdata <= {23'h000000, data_hold_r};
            OFS_START_HOLD:  prdata <= {7'h00, hold_quick_r, 7'h00, hold_slow_r};
            OFS_START_SETUP: prdata <= {7'h00, setup_quick_r, 7'h00, setup_slow_r};
            OFS_RAW_STATUS:  prdata <= raw_r;
            OFS_IRQ_MASK:    prdata <= mask_r;
            OFS_CONTROL:     prdata <= {31'h00000000, fast_mode_r};
            OFS_FAULT_CAUSE: prdata <= {30'h00000000, cause_r};
            default:         prdata <= 32'h00000000;
         endcase
      end
   end

   // Timing sequencer
   iict_phase_t phase_r;
   logic        cnt_load;
   logic [8:0]  cnt_limit;
   logic        cnt_exp;

   iict_counter u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .load    (cnt_load),
      .limit   (cnt_limit),
      .busy    (),
      .expired (cnt_exp)
   );

   always_comb begin
      cnt_load  = 1'b0;
      cnt_limit = data_hold_r;
      case (phase_r)
         IICT_IDLE: begin
            if (seq_start_req) begin
               cnt_load  = 1'b1;
               cnt_limit = fast_mode_r ? hold_quick_r : hold_slow_r;
            end else if (seq_restart_req) begin
               cnt_load  = 1'b1;
               cnt_limit = fast_mode_r ? setup_quick_r : setup_slow_r;
            end else if (scl_fall) begin
               cnt_load  = 1'b1;
               cnt_limit = data_hold_r;
            end
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= IICT_IDLE;
      end else begin
         case (phase_r)
            IICT_IDLE: begin
               if (seq_start_req) begin
                  phase_r <= IICT_START_HOLD;
               end else if (seq_restart_req) begin
                  phase_r <= IICT_SETUP;
               end else if (scl_fall) begin
                  phase_r <= IICT_DATA_HOLD;
               end
            end
            default: begin
               if (cnt_exp) begin
                  phase_r <= IICT_IDLE;
               end
            end
         endcase
      end
   end

   // Pin drive and completion pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_out          <= 1'b0;
         scl_oe           <= 1'b0;
         sda_out          <= 1'b0;
         sda_oe           <= 1'b0;
         seq_start_done   <= 1'b0;
         seq_restart_done <= 1'b0;
         seq_data_launch  <= 1'b0;
         own_cond_r       <= 1'b0;
      end else begin
         seq_start_done   <= 1'b0;
         seq_restart_done <= 1'b0;
         seq_data_launch  <= 1'b0;
         if (start_seen) begin
            own_cond_r <= 1'b0; // Held until own condition reaches the pins
         end
         if (phase_r == IICT_IDLE && seq_start_req) begin
            sda_oe     <= 1'b1; // Start: data low while clock high
            own_cond_r <= 1'b1;
         end
         if (phase_r == IICT_IDLE && seq_restart_req) begin
            sda_oe     <= 1'b0; // Release data for set-up
            scl_oe     <= 1'b0;
            own_cond_r <= 1'b1;
         end
         if (cnt_exp) begin
            case (phase_r)
               IICT_START_HOLD: begin
                  scl_oe         <= 1'b1;
                  seq_start_done <= 1'b1;
               end
               IICT_SETUP: begin
                  sda_oe           <= 1'b1;
                  seq_restart_done <= 1'b1;
               end
               IICT_DATA_HOLD: begin
                  sda_oe          <= !seq_tx_bit;
                  seq_data_launch <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // Checks
   logic [9:0] hold_wait_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_wait_r <= '0;
      end else if (cnt_load) begin
         hold_wait_r <= '0;
      end else if (phase_r != IICT_IDLE) begin
         hold_wait_r <= hold_wait_r + 10'h001;
      end
   end

   property p_masked_bits;
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == OFS_MASKED_VIEW) |=> prdata[BIT_MST_NOSTOP:BIT_ARB_LOST] ==
      ($past(raw_r[BIT_MST_NOSTOP:BIT_ARB_LOST]) & $past(mask_r[BIT_MST_NOSTOP:BIT_ARB_LOST]));
   endproperty
   a_masked_bits: assert property (p_masked_bits) else $error("masked bit mismatch");

   property p_nostop_irq;
      @(posedge pclk) disable iff (!presetn)
      (raw_r[BIT_MST_NOSTOP] && mask_r[BIT_MST_NOSTOP]) |-> irq || $past(wr_en);
   endproperty
   a_nostop_irq: assert property (p_nostop_irq) else $error("no-stop irq missing");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFS_IRQ_CLEAR && pwdata[BIT_MST_DONE] && !ev_set[BIT_MST_DONE]) |=> !raw_r[BIT_MST_DONE];
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_zero_keeps;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == OFS_IRQ_CLEAR && !pwdata[BIT_TX_OVERRUN] && raw_r[BIT_TX_OVERRUN]) |=> raw_r[BIT_TX_OVERRUN];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      ev_set[BIT_BUS_FAULT] |=> raw_r[BIT_BUS_FAULT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   property p_fault_cause;
      @(posedge pclk) disable iff (!presetn)
      bus_fault_evt |=> cause_r != CAUSE_NONE;
   endproperty
   a_fault_cause: assert property (p_fault_cause) else $error("no cause code");

   property p_data_hold_time;
      @(posedge pclk) disable iff (!presetn)
      (phase_r == IICT_DATA_HOLD && cnt_exp) |-> hold_wait_r == {1'b0, data_hold_r} + 10'h001;
   endproperty
   a_data_hold_time: assert property (p_data_hold_time) else $error("data hold count wrong");

   property p_start_scl_low;
      @(posedge pclk) disable iff (!presetn)
      (phase_r == IICT_START_HOLD && cnt_exp) |=> scl_oe && seq_start_done;
   endproperty
   a_start_scl_low: assert property (p_start_scl_low) else $error("clock not pulled low");

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn)
      $stable(mask_r) |-> irq == (|masked);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
endmodule : iict_top
`default_nettype wire

// [src/iict_pkg.sv]
`default_nettype none
package iict_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MASKED_VIEW  = 8'h34;
   localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h38;
   localparam logic [7:0] OFS_DATA_HOLD    = 8'h4C;
   localparam logic [7:0] OFS_START_HOLD   = 8'h50;
   localparam logic [7:0] OFS_START_SETUP  = 8'h58;
   localparam logic [7:0] OFS_RAW_STATUS   = 8'h60;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h64;
   localparam logic [7:0] OFS_CONTROL      = 8'h68;
   localparam logic [7:0] OFS_FAULT_CAUSE  = 8'h6C;
   // Interrupt bit positions
   localparam int BIT_TX_OVERRUN   = 3;
   localparam int BIT_SLV_RD_REQ   = 16;
   localparam int BIT_SLV_RD_EMPTY = 17;
   localparam int BIT_SLV_WR_REQ   = 18;
   localparam int BIT_MST_DONE     = 19;
   localparam int BIT_SLV_DONE     = 20;
   localparam int BIT_ARB_LOST     = 24;
   localparam int BIT_BUS_FAULT    = 25;
   localparam int BIT_MST_NOSTOP   = 28;
   localparam logic [31:0] IRQ_DEFINED_MASK = 32'h131F0008;
   // Counter field positions
   localparam int SLOW_LSB  = 0;
   localparam int QUICK_LSB = 16;
   localparam int CNT_W     = 9;
   // Reset values
   localparam logic [8:0] RST_DATA_HOLD   = 9'h014;
   localparam logic [8:0] RST_HOLD_SLOW   = 9'h0E2;
   localparam logic [8:0] RST_HOLD_QUICK  = 9'h03F;
   localparam logic [8:0] RST_SETUP_SLOW  = 9'h0E2;
   localparam logic [8:0] RST_SETUP_QUICK = 9'h01D;
   localparam logic [31:0] RST_MASK       = 32'h00000000;
   // Bus fault cause codes
   localparam logic [1:0] CAUSE_NONE  = 2'h0;
   localparam logic [1:0] CAUSE_START = 2'h1;
   localparam logic [1:0] CAUSE_STOP  = 2'h2;
   typedef enum logic [1:0] {
      IICT_IDLE, IICT_START_HOLD, IICT_SETUP, IICT_DATA_HOLD
   } iict_phase_t;
endpackage : iict_pkg
`default_nettype wire

// [src/iict_counter.sv]
`default_nettype none
module iict_counter
   import iict_pkg::*;
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] limit,
   // Result
   output logic                  busy,
   output logic                  expired
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] limit_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= '0;
         limit_r <= '0;
         busy    <= 1'b0;
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (load) begin
            count_r <= '0;
            limit_r <= limit;
            busy    <= 1'b1;
         end else if (busy) begin
            if (count_r == limit_r) begin
               busy    <= 1'b0;
               expired <= 1'b1;
            end else begin
               count_r <= count_r + 9'h001;
            end
         end
      end
   end
endmodule : iict_counter
`default_nettype wire

// [testbench/iict_bus_peer.sv]
`default_nettype none
module iict_bus_peer (
   // Open-drain pulls, high holds the line low
   output logic scl_low,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // Link clock burst, 80 ns period, still outside frames
   task automatic run_clock(input int n);
      #3;
      for (int i = 0; i < n; i++) begin
         scl_low = 1'b1;
         #40;
         scl_low = 1'b0;
         #40;
      end
   endtask : run_clock

   // Start while clock high, leaves both lines low
   task automatic make_start();
      #40 sda_low = 1'b1;
      #40 scl_low = 1'b1;
      #40;
   endtask : make_start

   // Clock released first, then data rises
   task automatic make_stop();
      scl_low = 1'b0;
      #40 sda_low = 1'b0;
      #40;
   endtask : make_stop
endmodule : iict_bus_peer
`default_nettype wire

// [testbench/iict_top_bench.sv]
`default_nettype none
module iict_top_bench
   import iict_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, seq_event_set, rd_val, m, bit_m;
   logic        scl_out, scl_oe, sda_out, sda_oe, irq, peer_scl_low, peer_sda_low;
   logic        seq_in_transaction, seq_start_req, seq_restart_req, seq_tx_bit;
   logic        seq_start_done, seq_restart_done, seq_data_launch;
   logic [8:0]  n_slow, n_quick;
   int          n_mismatch, compares, seed, lat;
   int          irq_bits [9] = '{3, 16, 17, 18, 19, 20, 24, 25, 28};
   wire         scl_w = !(scl_oe | peer_scl_low);
   wire         sda_w = !(sda_oe | peer_sda_low);

   iict_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
      .sda_oe(sda_oe), .seq_in_transaction(seq_in_transaction), .seq_start_req(seq_start_req),
      .seq_restart_req(seq_restart_req), .seq_tx_bit(seq_tx_bit), .seq_event_set(seq_event_set),
      .seq_start_done(seq_start_done), .seq_restart_done(seq_restart_done),
      .seq_data_launch(seq_data_launch), .irq(irq)
   );

   iict_bus_peer u_peer (.scl_low(peer_scl_low), .sda_low(peer_sda_low));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic give_verdict();
      if (n_mismatch == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Setup then access, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (pready !== 1'b1 && c < 100);
      if (pready !== 1'b1) n_mismatch++;
      rd_val = prdata;
      rd_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd_val, exp);
   endtask : rd

   task automatic pulse_evt(input logic [31:0] v);
      seq_event_set <= v;
      @(posedge pclk);
      seq_event_set <= 32'h0;
      @(posedge pclk);
   endtask : pulse_evt

   // Counts edges from the request edge until a done pulse is sampled
   task automatic timed(input logic restart, output int c);
      if (restart) seq_restart_req <= 1'b1;
      else seq_start_req <= 1'b1;
      c = 0;
      do begin
         @(posedge pclk);
         c++;
         seq_start_req   <= 1'b0;
         seq_restart_req <= 1'b0;
      end while (seq_start_done !== 1'b1 && seq_restart_done !== 1'b1 && c < 600);
   endtask : timed

   // Counts edges until the launch pulse is sampled
   task automatic wait_launch(output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (seq_data_launch !== 1'b1 && c < 600);
   endtask : wait_launch

   task automatic data_lat(output int c);
      @(negedge scl_w);
      wait_launch(c);
   endtask : data_lat

   // Done sampled one edge after its register, count plus two after request
   function automatic logic [31:0] exp_lat(input int md, input logic [8:0] s, input logic [8:0] q);
      return {23'h0, (md != 0) ? q : s} + 32'd4;
   endfunction : exp_lat

   // Three-flop sense plus count plus two, sampled one edge later
   function automatic logic [31:0] in_win(input int c, input logic [8:0] n);
      return {31'h0, (c >= int'(n) + 5) && (c <= int'(n) + 7)};
   endfunction : in_win

   initial begin
      #300000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      seed = 51433;
      n_mismatch = 0;
      compares = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {seq_in_transaction, seq_start_req, seq_restart_req, seq_tx_bit} = '0;
      seq_event_set = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_DATA_HOLD, 32'h14, "hold reset");
      rd(OFS_START_HOLD, 32'h003F00E2, "start hold reset");
      rd(OFS_START_SETUP, 32'h001D00E2, "setup reset");
      rd(OFS_IRQ_CLEAR, 32'h0, "clear reads zero");
      rd(OFS_IRQ_MASK, 32'h0, "mask reset");
      rd(8'h00, 32'h0, "unmapped data");
      chk("unmapped error", {31'h0, rd_err}, 32'h1);
      foreach (irq_bits[i]) begin
         bit_m = 32'h1 << irq_bits[i];
         pulse_evt(bit_m);
         rd(OFS_RAW_STATUS, bit_m, "raw set");
         m = $random(seed);
         wr(OFS_IRQ_MASK, m);
         rd(OFS_MASKED_VIEW, bit_m & m, "masked random");
         chk("irq random", {31'h0, irq}, {31'h0, |(bit_m & m)});
         wr(OFS_IRQ_MASK, bit_m);
         rd(OFS_MASKED_VIEW, bit_m, "masked on");
         chk("irq on", {31'h0, irq}, 32'h1);
         wr(OFS_IRQ_CLEAR, m & ~bit_m);
         rd(OFS_RAW_STATUS, bit_m, "zero ignored");
         wr(OFS_IRQ_CLEAR, bit_m);
         rd(OFS_RAW_STATUS, 32'h0, "cleared");
         chk("irq off", {31'h0, irq}, 32'h0);
         rd(OFS_IRQ_CLEAR, 32'h0, "clear reads zero");
      end
      // Event at the very edge of its clear write
      fork
         wr(OFS_IRQ_CLEAR, 32'h1 << BIT_TX_OVERRUN);
         begin
            @(posedge pclk);
            pulse_evt(32'h1 << BIT_TX_OVERRUN);
         end
      join
      rd(OFS_RAW_STATUS, 32'h1 << BIT_TX_OVERRUN, "set wins");
      wr(OFS_IRQ_CLEAR, 32'h1 << BIT_TX_OVERRUN);
      m = $random(seed);
      wr(OFS_DATA_HOLD, m);
      rd(OFS_DATA_HOLD, m & 32'h1FF, "hold rw");
      for (int md = 0; md < 2; md++) begin
         n_slow = 9'(2 + {$random(seed)} % 30);
         n_quick = 9'(2 + {$random(seed)} % 30);
         wr(OFS_CONTROL, 32'(md));
         wr(OFS_START_HOLD, {7'h0, n_quick, 7'h0, n_slow});
         rd(OFS_START_HOLD, {7'h0, n_quick, 7'h0, n_slow}, "hold fields");
         timed(1'b0, lat);
         chk("start latency", 32'(lat), exp_lat(md, n_slow, n_quick));
         chk("start scl", {31'h0, scl_oe}, 32'h1);
         chk("start sda", {31'h0, sda_oe}, 32'h1);
         chk("pin levels", {30'h0, scl_out, sda_out}, 32'h0);
         // Own clock fall: sensed three edges on, count plus two, seen one edge later
         wait_launch(lat);
         chk("start launch", 32'(lat), {23'h0, m[8:0]} + 32'd5);
         n_slow = 9'(2 + {$random(seed)} % 30);
         n_quick = 9'(2 + {$random(seed)} % 30);
         wr(OFS_START_SETUP, {7'h0, n_quick, 7'h0, n_slow});
         timed(1'b1, lat);
         chk("restart latency", 32'(lat), exp_lat(md, n_slow, n_quick));
         chk("restart sda", {31'h0, sda_oe}, 32'h1);
      end
      wr(OFS_CONTROL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         n_slow = 9'(1 + {$random(seed)} % 3);
         wr(OFS_DATA_HOLD, {23'h0, n_slow});
         seq_tx_bit <= i[0];
         fork
            u_peer.run_clock(1);
            data_lat(lat);
         join
         chk("launch window", in_win(lat, n_slow), 32'h1);
         chk("launch data", {31'h0, sda_oe}, {31'h0, !i[0]});
         @(posedge pclk);
      end
      seq_in_transaction <= 1'b1;
      u_peer.make_start();
      @(posedge pclk);
      rd(OFS_RAW_STATUS, 32'h1 << BIT_BUS_FAULT, "fault raw");
      rd(OFS_FAULT_CAUSE, {30'h0, CAUSE_START}, "cause start");
      wr(OFS_IRQ_CLEAR, 32'h1 << BIT_BUS_FAULT);
      rd(OFS_FAULT_CAUSE, 32'h0, "cause cleared");
      u_peer.make_stop();
      @(posedge pclk);
      rd(OFS_FAULT_CAUSE, {30'h0, CAUSE_STOP}, "cause stop");
      seq_in_transaction <= 1'b0;
      wr(OFS_IRQ_CLEAR, 32'h1 << BIT_BUS_FAULT);
      rd(OFS_RAW_STATUS, 32'h0, "fault cleared");
      give_verdict();
   end
endmodule : iict_top_bench
`default_nettype wire
